// ### rtl/fswp_pkg.sv
// Package for the flash status and write-protect block: opcodes, status
// field positions, reset values, widths, states and opcode classifiers.
// Assumes a single 100 MHz core clock and SPI mode 0 on the pins.
package fswp_pkg;
   // Opcodes handled directly by the block.
   localparam logic [7:0] OP_WRITE_STATUS_CMD = 8'h01;
   localparam logic [7:0] OP_CLEAR_LATCH_CMD = 8'h04;
   localparam logic [7:0] OP_READ_STATUS_CMD = 8'h05;
   localparam logic [7:0] OP_SET_LATCH_CMD = 8'h06;
   localparam logic [7:0] OP_RDFR = 8'h48;
   localparam logic [7:0] OP_RDERP = 8'h81;
   localparam logic [7:0] OP_RSTEN = 8'h66;
   localparam logic [7:0] OP_RST = 8'h99;
   localparam logic [7:0] OP_SUS_A = 8'h75;
   localparam logic [7:0] OP_SUS_B = 8'hb0;
   localparam logic [7:0] OP_CER_A = 8'hc7;
   localparam logic [7:0] OP_CER_B = 8'h60;
   // Status byte layout.
   localparam int SR_BUSY = 0;
   localparam int SR_WEL = 1;
   localparam int SR_LVL_LSB = 2;
   localparam int SR_QE = 6;
   localparam int SR_LOCK = 7;
   localparam logic [7:0] SR_RESET = 8'h00;
   localparam int LVL_W = 4;
   localparam int BLK_W = 9;
   localparam logic [3:0] LVL_ALL = 4'ha;
   localparam logic [9:0] BLK_COUNT = 10'h200;
   localparam logic [1:0] ADDR3_LAST = 2'h2;
   localparam logic [1:0] ADDR4_LAST = 2'h3;
   localparam logic [2:0] BIT_LAST = 3'h7;

   typedef enum logic [2:0] {
      FS_OPC = 3'h0,
      FS_ADDR = 3'h1,
      FS_DATA = 3'h2,
      FS_RD = 3'h3,
      FS_SKIP = 3'h4
   } fswp_state_t;

   // Program and erase opcodes that carry an address.
   function automatic logic fswp_is_pe(input logic [7:0] op);
      case (op)
         8'h02, 8'h12, 8'h32, 8'h38, 8'h34, 8'h3e, 8'hd7, 8'h20,
         8'h21, 8'h52, 8'h5c, 8'hd8, 8'hdc: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction

   // Four-byte address forms among the program and erase opcodes.
   function automatic logic fswp_is_addr4(input logic [7:0] op);
      case (op)
         8'h12, 8'h34, 8'h3e, 8'h21, 8'h5c, 8'hdc: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction

   // Latch-gated register and protection opcodes passed to the engine.
   function automatic logic fswp_is_reg_gated(input logic [7:0] op);
      case (op)
         8'h42, 8'h65, 8'h85, 8'h64, 8'h62, 8'h15, 8'h18, 8'hfd,
         8'he3, 8'he4, 8'h2f, 8'ha6, 8'h91, 8'he8: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction
endpackage

// ### rtl/fswp_prot_range.sv
// Decodes the protection level and area select into a per-block verdict.
// Assumes 512 blocks of 64 Kbyte and a combinational use by the caller.
`timescale 1ns/100ps
module fswp_prot_range (
   input wire logic [3:0] level_i,
   input wire logic bottom_i,
   input wire logic [8:0] block_i,
   output logic hit_o
);
   logic [9:0] span;
   logic [3:0] shift_amt;
   logic in_top;
   logic in_bottom;

   // Levels 1 to 9 cover 2^(n-1) blocks; level 0 none, 10 and up all.
   assign shift_amt = level_i - 4'h1;
   assign span = 10'h001 << shift_amt;
   assign in_top = {1'b0, block_i} >= (fswp_pkg::BLK_COUNT - span);
   assign in_bottom = {1'b0, block_i} < span;
   assign hit_o = (level_i == 4'h0) ? 1'b0 :
                  (level_i >= fswp_pkg::LVL_ALL) ? 1'b1 :
                  (bottom_i ? in_bottom : in_top);
endmodule // fswp_prot_range

// ### rtl/fswp_status_protect.sv
// Status register, write latch, busy flag and block protection of a
// serial flash, decoding commands from SPI mode 0 pins.
// Assumes SPI pins are asynchronous and an engine answers op_done_i.
`timescale 1ns/100ps
//////////////////////////////////////////////////////////////////////
module fswp_status_protect (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic sck_i,
   input wire logic cs_n_i,
   input wire logic si_i,
   input wire logic wp_n_i,
   input wire logic hold_n_i,
   input wire logic op_done_i,
   input wire logic bottom_area_select_i,
   output logic so_o,
   output logic so_oe_o,
   output logic op_start_o,
   output logic [7:0] op_code_o,
   output logic [31:0] op_addr_o,
   output logic aux_cmd_o,
   output logic [7:0] aux_code_o,
   output logic reject_o,
   output logic quad_mode_o,
   output logic hold_o,
   output logic [7:0] status_o
);
   logic [2:0] sck_sync_reg, cs_sync_reg;
   logic [1:0] si_sync_reg, wp_sync_reg, hold_sync_reg;
   fswp_pkg::fswp_state_t state_reg, state_next;
   logic [2:0] bit_cnt_reg, out_idx_reg;
   logic [7:0] shift_reg, code_reg, snap_reg, op_code_reg, aux_code_reg;
   logic [1:0] byte_cnt_reg;
   logic [31:0] addr_reg, op_addr_reg;
   logic addr4_reg, wel_reg, busy_reg, busy_pe_reg, qe_reg, lock_reg, bottom_reg;
   logic [3:0] level_reg;
   logic so_reg, op_start_reg, aux_reg, reject_reg;
   //////////////////////////////////////////////////////////////////
   // Pin synchronisers; the first stage feeds only the second.
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         sck_sync_reg <= 3'h0;
         cs_sync_reg <= 3'h7;
         si_sync_reg <= 2'h0;
         wp_sync_reg <= 2'h3;
         hold_sync_reg <= 2'h3;
      end else begin
         sck_sync_reg <= {sck_sync_reg[1:0], sck_i};
         cs_sync_reg <= {cs_sync_reg[1:0], cs_n_i};
         si_sync_reg <= {si_sync_reg[0], si_i};
         wp_sync_reg <= {wp_sync_reg[0], wp_n_i};
         hold_sync_reg <= {hold_sync_reg[0], hold_n_i};
      end
   end

   // Edge detection on the second and third stages only.
   logic sck_rise, sck_fall, cs_sel, bit_tick, byte_done;
   logic [7:0] byte_val;
   assign sck_rise = sck_sync_reg[1] & ~sck_sync_reg[2];
   assign sck_fall = ~sck_sync_reg[1] & sck_sync_reg[2];
   assign cs_sel = ~cs_sync_reg[1];
   assign bit_tick = sck_rise & cs_sel;
   assign byte_val = {shift_reg[6:0], si_sync_reg[1]};
   assign byte_done = bit_tick & (bit_cnt_reg == fswp_pkg::BIT_LAST);

   //////////////////////////////////////////////////////////////////
   // Opcode classification at the end of the first byte.
   logic opc_done, busy_ok, take, is_cer, gated_any;
   logic set_latch_cmd_go, clear_latch_cmd_go, read_status_cmd_go, write_status_cmd_ok, pe_ok, cer_go, reg_go, aux_go;
   assign opc_done = byte_done & (state_reg == fswp_pkg::FS_OPC);
   assign is_cer = (byte_val == fswp_pkg::OP_CER_A) | (byte_val == fswp_pkg::OP_CER_B);
   // While busy only reads of registers, resets and, during a program or erase, suspend pass through.
   assign busy_ok = (byte_val == fswp_pkg::OP_READ_STATUS_CMD) | (byte_val == fswp_pkg::OP_RDFR) |
                    (byte_val == fswp_pkg::OP_RDERP) | (byte_val == fswp_pkg::OP_RSTEN) |
                    (byte_val == fswp_pkg::OP_RST) |
                    (busy_pe_reg & ((byte_val == fswp_pkg::OP_SUS_A) |
                                    (byte_val == fswp_pkg::OP_SUS_B)));
   assign take = opc_done & (~busy_reg | busy_ok);
   assign gated_any = fswp_pkg::fswp_is_pe(byte_val) | fswp_pkg::fswp_is_reg_gated(byte_val) |
                      is_cer | (byte_val == fswp_pkg::OP_WRITE_STATUS_CMD);
   assign set_latch_cmd_go = take & (byte_val == fswp_pkg::OP_SET_LATCH_CMD);
   assign clear_latch_cmd_go = take & (byte_val == fswp_pkg::OP_CLEAR_LATCH_CMD);
   assign read_status_cmd_go = take & (byte_val == fswp_pkg::OP_READ_STATUS_CMD);
   // Gated commands go ahead only with the latch set.
   assign write_status_cmd_ok = take & wel_reg & (byte_val == fswp_pkg::OP_WRITE_STATUS_CMD);
   assign pe_ok = take & wel_reg & fswp_pkg::fswp_is_pe(byte_val);
   assign cer_go = take & wel_reg & is_cer & (level_reg == 4'h0);
   assign reg_go = take & wel_reg & fswp_pkg::fswp_is_reg_gated(byte_val);
   // Volatile writes, reads and resets are forwarded without the latch.
   assign aux_go = take & ~gated_any & ~set_latch_cmd_go & ~clear_latch_cmd_go & ~read_status_cmd_go;

   //////////////////////////////////////////////////////////////////
   // Address collection and range check for program and erase.
   logic [31:0] addr_next;
   logic [8:0] blk;
   logic addr_last, prot_hit, addr_go, addr_rej;
   assign addr_next = {addr_reg[23:0], byte_val};
   assign addr_last = byte_done & (state_reg == fswp_pkg::FS_ADDR) &
                      (byte_cnt_reg == (addr4_reg ? fswp_pkg::ADDR4_LAST :
                                                    fswp_pkg::ADDR3_LAST));
   assign blk = addr4_reg ? addr_next[24:16] : {1'b0, addr_next[23:16]};
   fswp_prot_range u_range (
      .level_i(level_reg),
      .bottom_i(bottom_reg),
      .block_i(blk),
      .hit_o(prot_hit)
   );
   assign addr_go = addr_last & ~prot_hit;
   assign addr_rej = addr_last & prot_hit;

   // Hardware lock; with quad enabled the pin is a data line, not a lock.
   logic wp_high, lock_now, write_status_cmd_done, write_status_cmd_go, start_go;
   assign wp_high = qe_reg | wp_sync_reg[1];
   assign lock_now = lock_reg & ~wp_high;
   assign write_status_cmd_done = byte_done & (state_reg == fswp_pkg::FS_DATA);
   assign write_status_cmd_go = write_status_cmd_done & ~lock_now;
   assign start_go = addr_go | write_status_cmd_go | cer_go | reg_go;

   //////////////////////////////////////////////////////////////////
   // Frame state machine; chip select high always returns to opcode.
   always_comb begin
      state_next = state_reg;
      if (!cs_sel) begin
         state_next = fswp_pkg::FS_OPC;
      end else begin
         case (state_reg)
            fswp_pkg::FS_OPC: begin
               if (opc_done) begin
                  if (read_status_cmd_go) begin
                     state_next = fswp_pkg::FS_RD;
                  end else if (write_status_cmd_ok) begin
                     state_next = fswp_pkg::FS_DATA;
                  end else if (pe_ok) begin
                     state_next = fswp_pkg::FS_ADDR;
                  end else begin
                     state_next = fswp_pkg::FS_SKIP;
                  end
               end
            end
            fswp_pkg::FS_ADDR: begin
               if (addr_last) begin
                  state_next = fswp_pkg::FS_SKIP;
               end
            end
            fswp_pkg::FS_DATA: begin
               if (byte_done) begin
                  state_next = fswp_pkg::FS_SKIP;
               end
            end
            default: state_next = state_reg;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         state_reg <= fswp_pkg::FS_OPC;
      end else begin
         state_reg <= state_next;
      end
   end

   // Bit and byte counters restart whenever chip select is released.
   always_ff @(posedge clk_i) begin
      if (!resetn_i || !cs_sel) begin
         bit_cnt_reg <= 3'h0;
         shift_reg <= 8'h00;
      end else if (bit_tick) begin
         bit_cnt_reg <= bit_cnt_reg + 3'h1;
         shift_reg <= byte_val;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i || state_reg != fswp_pkg::FS_ADDR) begin
         byte_cnt_reg <= 2'h0;
      end else if (byte_done) begin
         byte_cnt_reg <= byte_cnt_reg + 2'h1;
      end
   end

   // Address register and the opcode it belongs to.
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         addr_reg <= 32'h0;
         addr4_reg <= 1'b0;
         code_reg <= 8'h00;
      end else if (pe_ok) begin
         addr_reg <= 32'h0;
         addr4_reg <= fswp_pkg::fswp_is_addr4(byte_val);
         code_reg <= byte_val;
      end else if (byte_done && state_reg == fswp_pkg::FS_ADDR) begin
         addr_reg <= addr_next;
      end
   end

   //////////////////////////////////////////////////////////////////
   // Write latch: set wins over a clear in the same cycle.
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         wel_reg <= 1'b0;
      end else if (set_latch_cmd_go) begin
         wel_reg <= 1'b1;
      end else if (clear_latch_cmd_go || op_done_i) begin
         wel_reg <= 1'b0;
      end
   end

   // Busy spans from the engine start to its done, pass or fail.
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         busy_reg <= 1'b0;
         busy_pe_reg <= 1'b0;
      end else if (start_go) begin
         busy_reg <= 1'b1;
         busy_pe_reg <= addr_go | cer_go;
      end else if (op_done_i) begin
         busy_reg <= 1'b0;
         busy_pe_reg <= 1'b0;
      end
   end

   // Non-volatile bits reset to zero and change only on write-status.
   // The busy and latch fields of the written byte are discarded.
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         level_reg <= fswp_pkg::SR_RESET[fswp_pkg::SR_LVL_LSB +: fswp_pkg::LVL_W];
         qe_reg <= fswp_pkg::SR_RESET[fswp_pkg::SR_QE];
         lock_reg <= fswp_pkg::SR_RESET[fswp_pkg::SR_LOCK];
      end else if (write_status_cmd_go) begin
         level_reg <= byte_val[fswp_pkg::SR_LVL_LSB +: fswp_pkg::LVL_W];
         qe_reg <= byte_val[fswp_pkg::SR_QE];
         lock_reg <= byte_val[fswp_pkg::SR_LOCK];
      end
   end

   // Area select is one-time programmable, so it can only be set.
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         bottom_reg <= 1'b0;
      end else if (bottom_area_select_i) begin
         bottom_reg <= 1'b1;
      end
   end

   //////////////////////////////////////////////////////////////////
   // Status byte; the snapshot keeps repeated reads identical.
   logic [7:0] status_vec;
   assign status_vec = {lock_reg, qe_reg, level_reg, wel_reg, busy_reg};

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         snap_reg <= 8'h00;
         out_idx_reg <= fswp_pkg::BIT_LAST;
         so_reg <= 1'b0;
      end else if (read_status_cmd_go) begin
         snap_reg <= status_vec;
         out_idx_reg <= fswp_pkg::BIT_LAST;
      end else if (sck_fall && state_reg == fswp_pkg::FS_RD && cs_sel) begin
         so_reg <= snap_reg[out_idx_reg];
         out_idx_reg <= out_idx_reg - 3'h1;
      end
   end

   // Engine requests, forwarded commands and rejections, one cycle each.
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         op_start_reg <= 1'b0;
         op_code_reg <= 8'h00;
         op_addr_reg <= 32'h0;
         aux_reg <= 1'b0;
         aux_code_reg <= 8'h00;
         reject_reg <= 1'b0;
      end else begin
         op_start_reg <= start_go;
         aux_reg <= aux_go;
         reject_reg <= addr_rej | (take & wel_reg & is_cer & (level_reg != 4'h0)) |
                       (write_status_cmd_done & lock_now);
         if (start_go) begin
            op_code_reg <= addr_go ? code_reg : (write_status_cmd_go ? fswp_pkg::OP_WRITE_STATUS_CMD : byte_val);
            op_addr_reg <= addr_go ? addr_next : 32'h0;
         end
         if (aux_go) begin
            aux_code_reg <= byte_val;
         end
      end
   end

   // Outputs; hold only acts as a pause while quad mode is off.
   assign so_o = so_reg;
   assign so_oe_o = (state_reg == fswp_pkg::FS_RD) & cs_sel;
   assign op_start_o = op_start_reg;
   assign op_code_o = op_code_reg;
   assign op_addr_o = op_addr_reg;
   assign aux_cmd_o = aux_reg;
   assign aux_code_o = aux_code_reg;
   assign reject_o = reject_reg;
   assign quad_mode_o = qe_reg;
   assign hold_o = ~qe_reg & ~hold_sync_reg[1] & cs_sel;
   assign status_o = status_vec;

   //////////////////////////////////////////////////////////////////
   // Checks on the latch, busy flag, protection and lock behaviour.
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   wel_set_cause_a: assert property ($rose(wel_reg) |-> $past(set_latch_cmd_go))
      else $error("latch set without set-latch command");
   wel_clear_cause_a: assert property ($fell(wel_reg) |-> $past(clear_latch_cmd_go | op_done_i))
      else $error("latch cleared without cause");
   nv_bits_source_a: assert property (
      !$stable({level_reg, qe_reg, lock_reg}) |-> $past(write_status_cmd_go))
      else $error("status bits changed outside write-status");
   hw_lock_hold_a: assert property (
      (write_status_cmd_done && lock_reg && !qe_reg && !wp_sync_reg[1]) |=>
      $stable({level_reg, qe_reg, lock_reg}) && reject_o)
      else $error("locked write-status was not ignored");
   busy_start_a: assert property (start_go |=> busy_reg && op_start_o)
      else $error("busy not raised with engine start");
   busy_done_a: assert property (op_done_i && !start_go |=> !busy_reg)
      else $error("busy not cleared on completion");
   gated_latch_a: assert property (op_start_o |-> $past(wel_reg))
      else $error("write started without latch");
   chip_erase_a: assert property (
      (op_start_o && (op_code_o == fswp_pkg::OP_CER_A || op_code_o == fswp_pkg::OP_CER_B))
      |-> level_reg == 4'h0)
      else $error("whole erase with protection set");
   prot_reject_a: assert property (addr_rej |=> reject_o && !op_start_o)
      else $error("protected target not rejected");
   busy_ignore_a: assert property (
      (opc_done && busy_reg && !busy_ok) |=> state_reg == fswp_pkg::FS_SKIP && !aux_cmd_o)
      else $error("command taken while busy");
   write_status_cmd_seen_c: cover property (write_status_cmd_go ##1 op_start_o);
   read_status_cmd_seen_c: cover property (read_status_cmd_go ##[1:300] sck_fall && so_oe_o);
   reject_seen_c: cover property (addr_rej);
   suspend_seen_c: cover property (busy_pe_reg && aux_go);
endmodule // fswp_status_protect

// ### tb/fswp_host_model.sv
// Host controller model that drives SPI mode 0 frames into the status block.
// Assumes a 100 MHz core clock; sck runs at 160 ns and idles low between frames.
`timescale 1ns/100ps
module fswp_host_model (
   input wire logic clk_i,
   input wire logic so_i,
   output logic sck_o,
   output logic cs_n_o,
   output logic si_o
);
   // Idle state: deselected, clock low.
   initial begin
      sck_o = 1'b0;
      cs_n_o = 1'b1;
      si_o = 1'b0;
   end

   // Sends n whole bytes from the top of d, MSB first.
   // Every bit seen on so at a rising sck edge is shifted into rd.
   task automatic xfer(input logic [39:0] d, input int n, output logic [15:0] rd);
      rd = 16'h0000;
      @(negedge clk_i);
      cs_n_o = 1'b0;
      for (int i = 0; i < 8 * n; i++) begin
         si_o = d[39 - i];
         repeat (8) @(negedge clk_i);
         sck_o = 1'b1;
         rd = {rd[14:0], so_i};
         repeat (8) @(negedge clk_i);
         sck_o = 1'b0;
      end
      repeat (8) @(negedge clk_i);
      cs_n_o = 1'b1;
      si_o = ~si_o; // A released line shows the inverse, so no stale bit can pass.
      repeat (8) @(negedge clk_i);
   endtask
endmodule // fswp_host_model

// ### tb/fswp_status_protect_tb.sv
// Self-checking bench for the flash status and write-protect block.
// Assumes the host model for SPI frames; the bench plays the program engine.
`timescale 1ns/100ps
module fswp_status_protect_tb;
   logic clk_i, resetn_i, wp_n_i, op_done_i, bsel, sck, cs_n, si, so;
   logic so_oe, op_start, aux_cmd, reject, quad, hold, hold_n;
   logic saw_start, saw_reject, saw_aux;
   logic [7:0] op_code, aux_code, status;
   logic [31:0] op_addr;
   logic [15:0] rd;
   int errors, comparisons;

   fswp_status_protect dut (.clk_i(clk_i), .resetn_i(resetn_i), .sck_i(sck), .cs_n_i(cs_n),
      .si_i(si), .wp_n_i(wp_n_i), .hold_n_i(hold_n), .op_done_i(op_done_i),
      .bottom_area_select_i(bsel), .so_o(so), .so_oe_o(so_oe), .op_start_o(op_start),
      .op_code_o(op_code), .op_addr_o(op_addr), .aux_cmd_o(aux_cmd),
      .aux_code_o(aux_code), .reject_o(reject), .quad_mode_o(quad), .hold_o(hold),
      .status_o(status));
   fswp_host_model host (.clk_i(clk_i), .so_i(so), .sck_o(sck), .cs_n_o(cs_n), .si_o(si));

   // Core clock, 10 ns period.
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   // One-cycle pulses are caught here so that frames can be checked afterwards.
   always @(posedge clk_i) begin
      if (op_start) saw_start <= 1'b1;
      if (reject) saw_reject <= 1'b1;
      if (aux_cmd) saw_aux <= 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask

   task automatic check1(input logic got, input logic exp, input string what);
      check8({7'h00, got}, {7'h00, exp}, what);
   endtask

   task automatic cmd(input logic [39:0] d, input int n);
      saw_start = 1'b0;
      saw_reject = 1'b0;
      saw_aux = 1'b0;
      host.xfer(d, n, rd);
   endtask

   // Engine completion pulse, one cycle.
   task automatic done();
      @(negedge clk_i);
      op_done_i = 1'b1;
      @(negedge clk_i);
      op_done_i = 1'b0;
      repeat (2) @(negedge clk_i);
   endtask

   // Looks at the pause and output enable pins in the middle of a frame.
   task automatic probe(input int wait_n, input logic exp_hold, input logic exp_oe,
                        input string what);
      repeat (wait_n) @(negedge clk_i);
      check1(hold, exp_hold, what);
      check1(so_oe, exp_oe, what);
   endtask

   task automatic final_report();
      $display("errors=%0d comparisons=%0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Watchdog: the sequence needs well under 200 us.
   initial begin
      #300us;
      errors++;
      $display("unexpected at %0t: run did not finish", $time);
      final_report();
   end

   // Main sequence; every write-class frame meant to run follows a set-latch frame, except the program into block 507, which follows the rejected program.
   initial begin
      errors = 0;
      comparisons = 0;
      resetn_i = 1'b0;
      wp_n_i = 1'b1;
      hold_n = 1'b1;
      op_done_i = 1'b0;
      bsel = 1'b0;
      saw_start = 1'b0;
      saw_reject = 1'b0;
      saw_aux = 1'b0;
      repeat (2) @(negedge clk_i);
      resetn_i = 1'b1;
      repeat (3) @(negedge clk_i);
      check8(status, 8'h00, "reset status");
      cmd({8'h01, 8'h3c, 24'h0}, 2);
      check8(status, 8'h00, "status write without latch");
      // The pause pin acts while quad mode is off and chip select is low.
      hold_n = 1'b0;
      fork
         cmd({8'h06, 32'h0}, 1);
         probe(12, 1'b1, 1'b0, "hold pause with quad off");
      join
      hold_n = 1'b1;
      check8(status, 8'h02, "set latch");
      cmd({8'h04, 32'h0}, 1);
      check8(status, 8'h00, "clear latch");
      // Level 3, lock set; data bit 1 low must not touch the latch.
      cmd({8'h06, 32'h0}, 1);
      cmd({8'h01, 8'h8c, 24'h0}, 2);
      check8(status, 8'h8f, "status after write");
      check8(op_code, 8'h01, "status write start code");
      cmd({8'h04, 32'h0}, 1);
      check8(status, 8'h8f, "clear ignored while busy");
      fork
         cmd({8'h05, 32'h0}, 3);
         probe(140, 1'b0, 1'b1, "status read output enable");
      join
      check8(rd[15:8], 8'h8f, "first status read");
      check8(rd[7:0], 8'h8f, "repeated status read");
      done();
      check8(status, 8'h8c, "completion");
      // Top mapping, level 3 protects blocks 508 to 511.
      cmd({8'h06, 32'h0}, 1);
      cmd({8'h12, 32'h01fc0000}, 5);
      check1(saw_reject, 1'b1, "program into top block 508");
      check1(saw_start, 1'b0, "no start when protected");
      cmd({8'h12, 32'h01fbffff}, 5);
      check1(saw_start, 1'b1, "program into block 507");
      check8(op_addr[31:24], 8'h01, "program address top");
      check8(op_addr[7:0], 8'hff, "program address low");
      done();
      cmd({8'h06, 32'h0}, 1);
      cmd({8'hc7, 32'h0}, 1);
      check1(saw_reject, 1'b1, "whole erase with level set");
      // Lock with protect pin low refuses the write.
      wp_n_i = 1'b0;
      repeat (4) @(negedge clk_i);
      cmd({8'h06, 32'h0}, 1);
      cmd({8'h01, 8'h00, 24'h0}, 2);
      check1(saw_reject, 1'b1, "locked status write");
      check8(status, 8'h8e, "locked status kept");
      wp_n_i = 1'b1;
      repeat (4) @(negedge clk_i);
      cmd({8'h06, 32'h0}, 1);
      cmd({8'h01, 8'h40, 24'h0}, 2);
      check8(status, 8'h43, "unlocked status write");
      done();
      check1(quad, 1'b1, "quad pins enabled");
      // Whole erase runs at level 0; the pause pin is a data line in quad mode.
      hold_n = 1'b0;
      fork
         cmd({8'h06, 32'h0}, 1);
         probe(12, 1'b0, 1'b0, "hold ignored in quad mode");
      join
      hold_n = 1'b1;
      cmd({8'hc7, 32'h0}, 1);
      check1(saw_start, 1'b1, "whole erase at level 0");
      check8(op_code, 8'hc7, "whole erase code");
      cmd({8'h99, 32'h0}, 1);
      check1(saw_aux, 1'b1, "reset taken while busy");
      check8(aux_code, 8'h99, "reset code while busy");
      done();
      // Bottom mapping is set by one pulse and stays.
      @(negedge clk_i);
      bsel = 1'b1;
      @(negedge clk_i);
      bsel = 1'b0;
      cmd({8'h06, 32'h0}, 1);
      cmd({8'h01, 8'h44, 24'h0}, 2);
      done();
      check8(status, 8'h44, "level 1 written");
      cmd({8'h06, 32'h0}, 1);
      cmd({8'h12, 32'h0000ffff}, 5);
      check1(saw_reject, 1'b1, "bottom block 0 protected");
      cmd({8'h06, 32'h0}, 1);
      cmd({8'h12, 32'h01ff0000}, 5);
      check1(saw_start, 1'b1, "top block open in bottom mode");
      cmd({8'h75, 32'h0}, 1);
      check1(saw_aux, 1'b1, "suspend during program");
      check8(aux_code, 8'h75, "suspend code");
      done();
      cmd({8'h42, 8'h00, 24'h0}, 2);
      check1(saw_start, 1'b0, "gated register write without latch");
      cmd({8'hc0, 8'h00, 24'h0}, 2);
      check1(saw_aux, 1'b1, "volatile write without latch");
      check8(aux_code, 8'hc0, "volatile write code");
      final_report();
   end
endmodule // fswp_status_protect_tb
